//--- serial_port_control_status_tb.sv
`timescale 1ns/10ps
module serial_port_control_status_tb;
    import spc_pkg::*;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic sfr_wr_in = 1'b0;
    logic sfr_rd_in = 1'b0;
    logic [7:0] sfr_addr_in = 8'h00;
    logic [7:0] sfr_wdata_in = 8'h00;
    logic [7:0] sfr_rdata_out;
    logic rxd_out;
    logic rxd_oe_out;
    logic txd_out;
    logic line;
    logic [7:0] v;
    logic [7:0] got;
    logic prev;
    logic tick = 1'b0;
    logic [10:0] fr;
    int rises;
    int first_c;
    int span;
    int failures = 0;
    int num_checks = 0;
    // Register cases: address, written value, value read back
    logic [23:0] rows [4] = '{24'h98_FFFC, 24'h98_5A58, 24'hA0_FF00, 24'h98_0000};
    // Mode 0 transmit cases: control value, status after, clocks from first to last shift clock rise
    logic [23:0] m0_rows [2] = '{24'h20_221C, 24'h00_0254};
    // Receive cases: control value, dropped byte, accepted byte, status after the accepted frame
    logic [31:0] rx_rows [2] = '{32'h7022_6975, 32'hB011_96B5};
    // Pin seen by the receiver: the block when it drives, else the far device
    wire logic rxd_pin = rxd_oe_out ? rxd_out : line;

    always #50 clk_in = ~clk_in;

    // Sample tick for modes 1 and 3 every other clock, so one bit lasts 32 clocks
    always @(posedge clk_in) tick <= ~tick;

    spc_serial_port #(.FIFO_DEPTH(4)) dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .sfr_addr_in(sfr_addr_in), .sfr_wdata_in(sfr_wdata_in), .sfr_wr_in(sfr_wr_in),
        .sfr_rd_in(sfr_rd_in), .sfr_rdata_out(sfr_rdata_out), .baud16_tick_in(tick),
        .mode2_double_in(1'b1), .rxd_in(rxd_pin), .rxd_out(rxd_out), .rxd_oe_out(rxd_oe_out),
        .txd_out(txd_out));
    spc_partner far_u (.clk_in(clk_in), .sclk_in(txd_out), .line_out(line));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // One-cycle strobes, each held until the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        sfr_addr_in <= a;
        sfr_wdata_in <= d;
        sfr_wr_in <= 1'b1;
        @(posedge clk_in);
        sfr_wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in);
        sfr_addr_in <= a;
        sfr_rd_in <= 1'b1;
        @(posedge clk_in);
        sfr_rd_in <= 1'b0;
        @(posedge clk_in);
        d = sfr_rdata_out;
    endtask

    task automatic results;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Poll the status register; a flag that never rises ends the run
    task automatic wait_flag(input logic [7:0] mask);
        logic [7:0] s;
        for (int n = 0; n < 200; n++) begin
            rd(SPC_ADDR_CTRL, s);
            if ((s & mask) !== 8'h00) return;
        end
        failures++;
        $display("ERROR %0t: flag wait timed out", $time);
        results();
    endtask

    initial begin
        repeat (10) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        check({7'h00, txd_out}, 8'h01);
        rd(SPC_ADDR_CTRL, v);
        check(v, SPC_CTRL_RESET);
        $display("reset test done");
        // Ordinary register accesses, unmapped address included
        foreach (rows[i]) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16], v);
            check(v, rows[i][7:0]);
        end
        $display("register table done");
        // Mode 0 transmit at crystal/4 and crystal/12: eight shift clocks, LSB first
        foreach (m0_rows[i]) begin
            wr(SPC_ADDR_CTRL, m0_rows[i][23:16]);
            wr(SPC_ADDR_BUF, 8'hA5);
            got = 8'h00;
            rises = 0;
            first_c = 0;
            span = 0;
            prev = 1'b1;
            for (int c = 0; c < 110; c++) begin
                @(posedge clk_in);
                if (txd_out && !prev) begin
                    got = {rxd_pin, got[7:1]};
                    if (rises == 0) begin
                        first_c = c;
                    end
                    span = c - first_c;
                    rises++;
                end
                prev = txd_out;
            end
            check(got, 8'hA5);
            check(rises[7:0], 8'h08);
            check(span[7:0], m0_rows[i][7:0]);
            rd(SPC_ADDR_CTRL, v);
            check(v, m0_rows[i][15:8]);
        end
        $display("mode 0 transmit done");
        // Mode 0 receive, software zero clears the transmit flag
        fork
            far_u.shift_byte(8'h3C);
        join_none
        wr(SPC_ADDR_CTRL, 8'h30);
        wait_flag(8'h01);
        rd(SPC_ADDR_CTRL, v);
        check(v, 8'h31);
        rd(SPC_ADDR_BUF, v);
        check(v, 8'h3C);
        $display("mode 0 receive done");
        // Address filtering in modes 1 and 2: a low stop or ninth bit drops the frame
        foreach (rx_rows[i]) begin
            wr(SPC_ADDR_CTRL, rx_rows[i][31:24]);
            far_u.send_frame(rx_rows[i][23:16], 1'b0, 32);
            rd(SPC_ADDR_CTRL, v);
            check(v, rx_rows[i][31:24]);
            far_u.send_frame(rx_rows[i][15:8], 1'b1, 32);
            rd(SPC_ADDR_CTRL, v);
            check(v, rx_rows[i][7:0]);
            rd(SPC_ADDR_BUF, v);
            check(v, rx_rows[i][15:8]);
        end
        $display("async receive done");
        // Receiver disabled: frame ignored, buffer stays empty
        wr(SPC_ADDR_CTRL, 8'h80);
        far_u.send_frame(8'h42, 1'b1, 32);
        rd(SPC_ADDR_CTRL, v);
        check(v, 8'h80);
        rd(SPC_ADDR_BUF, v);
        check(v, 8'h00);
        $display("receive disable done");
        // Mode 3 transmit: line sampled mid-bit, ninth bit taken from tx9
        wr(SPC_ADDR_CTRL, 8'hC8);
        wr(SPC_ADDR_BUF, 8'h5B);
        for (int b = 0; b < 11; b++) begin
            repeat ((b == 0) ? 17 : 32) @(posedge clk_in);
            fr = {txd_out, fr[10:1]};
        end
        check(fr[8:1], 8'h5B);
        check({5'h00, fr[10:9], fr[0]}, 8'h06);
        rd(SPC_ADDR_CTRL, v);
        check(v, 8'hCA);
        $display("mode 3 transmit done");
        results();
    end
endmodule // serial_port_control_status_tb

//--- spc_fifo.sv
`timescale 1ns/10ps
module spc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] count_ff;
    logic push;
    logic pop;

    // Honest full and empty straight from the occupancy count
    assign in_ready_out = (count_ff != (AW+1)'(DEPTH));
    assign out_valid_out = (count_ff != '0);
    assign out_data_out = mem_ff[rd_ptr_ff];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    // Storage needs no reset; only words below the count are ever read
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data_in;
        end
    end

    // Pointers wrap explicitly so any depth works
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
            end
        end
    end

    // Occupancy
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            count_ff <= '0;
        end else if (push && !pop) begin
            count_ff <= count_ff + 1'b1;
        end else if (pop && !push) begin
            count_ff <= count_ff - 1'b1;
        end
    end

endmodule // spc_fifo

//--- spc_partner.sv
`timescale 1ns/10ps
// Far-side serial device; it drives its line high when idle
module spc_partner (
    input wire logic clk_in,
    input wire logic sclk_in,
    output logic line_out
);
    initial line_out = 1'b1;

    // shift source, LSB first
    // Next bit goes out just after the shift clock rises, well clear of the sample point
    task automatic shift_byte(input logic [7:0] data);
        for (int i = 0; i < 8; i++) begin
            line_out <= data[i];
            @(posedge sclk_in);
        end
        line_out <= 1'b1;
    endtask

    // async frame sender
    // Start, eight data bits, ninth bit, stop; in mode 1 the ninth slot is the stop bit
    task automatic send_frame(input logic [7:0] data, input logic ninth, input int bit_clks);
        logic [10:0] frame;
        frame = {1'b1, ninth, data, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge clk_in);
            line_out <= frame[i];
            repeat (bit_clks - 1) @(posedge clk_in);
        end
    endtask
endmodule // spc_partner

//--- spc_pkg.sv
package spc_pkg;

    // Register addresses on the special-function-register bus
    localparam logic [7:0] SPC_ADDR_CTRL = 8'h98;
    localparam logic [7:0] SPC_ADDR_BUF = 8'h99;

    // Field positions inside the control/status register
    localparam int SPC_BIT_MODE_HI = 7;
    localparam int SPC_BIT_MODE_LO = 6;
    localparam int SPC_BIT_MPE = 5;
    localparam int SPC_BIT_REN = 4;
    localparam int SPC_BIT_TX9 = 3;
    localparam int SPC_BIT_RX9 = 2;
    localparam int SPC_BIT_TXDONE = 1;
    localparam int SPC_BIT_RXDONE = 0;

    // Reset value of the control/status register
    localparam logic [7:0] SPC_CTRL_RESET = 8'h00;

    // Mode 0 shift clock period in crystal clocks
    localparam logic [3:0] SPC_M0_DIV_SLOW = 4'hc;
    localparam logic [3:0] SPC_M0_DIV_FAST = 4'h4;

    // Mode 2 prescale to the 16x sample tick (64 or 32 clocks per bit)
    localparam logic [1:0] SPC_M2_PRE_SLOW = 2'h3;
    localparam logic [1:0] SPC_M2_PRE_FAST = 2'h1;

    // Sixteen ticks per bit, majority of ticks 7, 8 and 9
    localparam logic [3:0] SPC_TICK_LAST = 4'hf;
    localparam logic [3:0] SPC_SAMPLE_A = 4'h7;
    localparam logic [3:0] SPC_SAMPLE_B = 4'h8;
    localparam logic [3:0] SPC_SAMPLE_C = 4'h9;

    // Receive FIFO depth
    localparam int SPC_FIFO_DEPTH = 32;

    typedef enum logic [1:0] {
        SPC_MODE0 = 2'b00,
        SPC_MODE1 = 2'b01,
        SPC_MODE2 = 2'b10,
        SPC_MODE3 = 2'b11
    } spc_mode_t;

    typedef enum logic [2:0] {
        SPC_ST_IDLE = 3'b000,
        SPC_ST_START = 3'b001,
        SPC_ST_DATA = 3'b010,
        SPC_ST_NINTH = 3'b011,
        SPC_ST_STOP = 3'b100
    } spc_frame_t;

endpackage

//--- spc_serial_port.sv
// Behaviour
// - Control/status register sits at address 98H.
// - Bits: mode high, mode low, mpe, ren, tx9, rx9, flags.
// - Two mode bits select modes zero to three.
// - Mode 0, mpe clear: shift clock crystal/12.
// - Mode 0, mpe set: shift clock crystal/4.
// - Mode 1, mpe set: receive flag needs high stop.
// - Modes 2/3: mpe silences unaddressed slave receivers.
// - Modes 2/3, mpe set: accept only ninth high.
// - Receive only while receive enable is set.
// - Modes 2/3 send tx ninth bit as bit nine.
// - Rx ninth field: ninth bit, stop bit, unused.
// - Mode 0: transmit flag at end of bit eight.
// - Modes 1-3: transmit flag at stop bit start.
// - Mode 0: receive flag at end of bit eight.
// - Mode 1: receive flag after last stop sample.
// - Modes 2/3: receive flag at last stop sample.
// - Mode 0 is an 8-bit shift register.
// - Mode 0 always drives shift clock on transmit pin.
`timescale 1ns/10ps
module spc_serial_port
    import spc_pkg::*;
#(
    parameter int FIFO_DEPTH = SPC_FIFO_DEPTH
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic sfr_wr_in,
    input wire logic sfr_rd_in,
    output logic [7:0] sfr_rdata_out,
    input wire logic baud16_tick_in,
    input wire logic mode2_double_in,
    input wire logic rxd_in,
    output logic rxd_out,
    output logic rxd_oe_out,
    output logic txd_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    spc_mode_t mode_ff;
    logic mpe_ff, ren_ff, tb8_ff, rb8_ff, ti_ff, ri_ff;
    logic wr_ctrl, wr_buf, rd_buf;
    logic [7:0] ctrl_value;
    logic [7:0] rdata_ff;
    logic ti_set, ri_set;
    logic fifo_in_ready, fifo_out_valid, fifo_push;
    logic [7:0] fifo_out_data, fifo_push_data;
    // Mode 0 engine
    logic m0_active_ff, m0_dir_rx_ff;
    logic [3:0] m0_cnt_ff;
    logic [2:0] m0_bit_ff;
    logic [7:0] m0_shift_ff;
    logic [3:0] m0_div, m0_half;
    logic m0_sclk, m0_rise, m0_end, m0_done, m0_tx_start, m0_rx_start;
    // Tick generation
    logic [1:0] pre_cnt_ff;
    logic pre_tick, async_tick;
    // Asynchronous transmitter
    spc_frame_t tx_state_ff;
    logic [3:0] tx_cnt_ff;
    logic [2:0] tx_bit_ff;
    logic [7:0] tx_shift_ff;
    logic tx_ninth_ff, tx_adv, tx_start, tx_to_stop, tx_line;
    // Asynchronous receiver
    spc_frame_t rx_state_ff;
    logic [3:0] rx_cnt_ff;
    logic [2:0] rx_bit_ff;
    logic [7:0] rx_shift_ff;
    logic rx_prev_ff, rx_smp_a_ff, rx_smp_b_ff, rx_ninth_ff;
    logic rx_start, rx_mid, rx_adv, rx_bit_now, rx_ninth_val, rx_stop_mid, rx_accept;
    logic txd_ff, nxt_txd;

    always_comb begin
        wr_ctrl = 1'b0;
        wr_buf = 1'b0;
        rd_buf = 1'b0;
        if (sfr_addr_in == SPC_ADDR_CTRL) begin
            wr_ctrl = sfr_wr_in;
        end else if (sfr_addr_in == SPC_ADDR_BUF) begin
            wr_buf = sfr_wr_in;
            rd_buf = sfr_rd_in;
        end
    end

    assign ctrl_value = {mode_ff, mpe_ff, ren_ff, tb8_ff, rb8_ff, ti_ff, ri_ff};

    // software fields, mode high is the upper bit
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            mode_ff <= spc_mode_t'(SPC_CTRL_RESET[SPC_BIT_MODE_HI:SPC_BIT_MODE_LO]);
            mpe_ff <= SPC_CTRL_RESET[SPC_BIT_MPE];
            ren_ff <= SPC_CTRL_RESET[SPC_BIT_REN];
            tb8_ff <= SPC_CTRL_RESET[SPC_BIT_TX9];
        end else if (wr_ctrl) begin
            mode_ff <= spc_mode_t'(sfr_wdata_in[SPC_BIT_MODE_HI:SPC_BIT_MODE_LO]);
            mpe_ff <= sfr_wdata_in[SPC_BIT_MPE];
            ren_ff <= sfr_wdata_in[SPC_BIT_REN];
            tb8_ff <= sfr_wdata_in[SPC_BIT_TX9];
        end
    end

    // received ninth or stop bit; the frame wins over a write
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rb8_ff <= SPC_CTRL_RESET[SPC_BIT_RX9];
        end else if (rx_accept) begin
            rb8_ff <= rx_ninth_val;
        end else if (wr_ctrl) begin
            rb8_ff <= sfr_wdata_in[SPC_BIT_RX9];
        end
    end

    // flags set by hardware only, a written zero clears, set wins
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ti_ff <= SPC_CTRL_RESET[SPC_BIT_TXDONE];
            ri_ff <= SPC_CTRL_RESET[SPC_BIT_RXDONE];
        end else begin
            if (ti_set) begin
                ti_ff <= 1'b1;
            end else if (wr_ctrl && !sfr_wdata_in[SPC_BIT_TXDONE]) begin
                ti_ff <= 1'b0;
            end
            if (ri_set) begin
                ri_ff <= 1'b1;
            end else if (wr_ctrl && !sfr_wdata_in[SPC_BIT_RXDONE]) begin
                ri_ff <= 1'b0;
            end
        end
    end

    // Read data is registered; unmapped addresses read zero
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rdata_ff <= 8'h00;
        end else if (sfr_rd_in) begin
            if (sfr_addr_in == SPC_ADDR_CTRL) begin
                rdata_ff <= ctrl_value;
            end else if (sfr_addr_in == SPC_ADDR_BUF) begin
                rdata_ff <= fifo_out_valid ? fifo_out_data : 8'h00;
            end else begin
                rdata_ff <= 8'h00;
            end
        end
    end
    assign sfr_rdata_out = rdata_ff;

    // shift clock period picked by the mpe bit
    assign m0_div = mpe_ff ? SPC_M0_DIV_FAST : SPC_M0_DIV_SLOW;
    assign m0_half = m0_div >> 1;
    assign m0_sclk = m0_active_ff && (m0_cnt_ff >= m0_half);
    assign m0_rise = m0_active_ff && (m0_cnt_ff == m0_half - 4'h1);
    assign m0_end = m0_active_ff && (m0_cnt_ff == m0_div - 4'h1);
    assign m0_done = m0_end && (m0_bit_ff == 3'h7);
    // mode 0 reception starts only when enabled and the flag is clear
    assign m0_rx_start = (mode_ff == SPC_MODE0) && ren_ff && !ri_ff && !m0_active_ff && fifo_in_ready && !wr_buf;
    assign m0_tx_start = (mode_ff == SPC_MODE0) && wr_buf && !m0_active_ff;

    // mode 0 sequencing, eight bits LSB first
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            m0_active_ff <= 1'b0;
            m0_dir_rx_ff <= 1'b0;
            m0_cnt_ff <= 4'h0;
            m0_bit_ff <= 3'h0;
        end else if (m0_tx_start || m0_rx_start) begin
            m0_active_ff <= 1'b1;
            m0_dir_rx_ff <= m0_rx_start;
            m0_cnt_ff <= 4'h0;
            m0_bit_ff <= 3'h0;
        end else if (m0_end) begin
            m0_cnt_ff <= 4'h0;
            m0_bit_ff <= m0_bit_ff + 3'h1;
            m0_active_ff <= !m0_done;
        end else if (m0_active_ff) begin
            m0_cnt_ff <= m0_cnt_ff + 4'h1;
        end
    end

    // data shifts out at bit end, in on the rising shift clock
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            m0_shift_ff <= 8'hff;
        end else if (m0_tx_start) begin
            m0_shift_ff <= sfr_wdata_in;
        end else if (m0_rise && m0_dir_rx_ff) begin
            m0_shift_ff <= {rxd_in, m0_shift_ff[7:1]};
        end else if (m0_end && !m0_dir_rx_ff) begin
            m0_shift_ff <= {1'b1, m0_shift_ff[7:1]};
        end
    end

    // Mode 2 prescaler; modes 1 and 3 use the external timer tick
    assign pre_tick = (pre_cnt_ff == (mode2_double_in ? SPC_M2_PRE_FAST : SPC_M2_PRE_SLOW));
    assign async_tick = (mode_ff == SPC_MODE2) ? pre_tick : baud16_tick_in;
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pre_cnt_ff <= 2'h0;
        end else begin
            pre_cnt_ff <= pre_tick ? 2'h0 : pre_cnt_ff + 2'h1;
        end
    end

    // Transmit control; a write while busy is dropped
    assign tx_start = (mode_ff != SPC_MODE0) && wr_buf && (tx_state_ff == SPC_ST_IDLE);
    assign tx_adv = async_tick && (tx_cnt_ff == SPC_TICK_LAST) && (tx_state_ff != SPC_ST_IDLE);
    assign tx_to_stop = tx_adv && ((tx_state_ff == SPC_ST_NINTH) ||
        ((tx_state_ff == SPC_ST_DATA) && (tx_bit_ff == 3'h7) && (mode_ff == SPC_MODE1)));

    // ninth bit captured from tx9 when the byte is written
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tx_state_ff <= SPC_ST_IDLE;
            tx_cnt_ff <= 4'h0;
            tx_bit_ff <= 3'h0;
            tx_shift_ff <= 8'hff;
            tx_ninth_ff <= 1'b1;
        end else if (tx_start) begin
            tx_state_ff <= SPC_ST_START;
            tx_cnt_ff <= 4'h0;
            tx_bit_ff <= 3'h0;
            tx_shift_ff <= sfr_wdata_in;
            tx_ninth_ff <= tb8_ff;
        end else if (tx_adv) begin
            tx_cnt_ff <= 4'h0;
            case (tx_state_ff)
                SPC_ST_START: begin
                    tx_state_ff <= SPC_ST_DATA;
                end
                SPC_ST_DATA: begin
                    tx_shift_ff <= {1'b1, tx_shift_ff[7:1]};
                    tx_bit_ff <= tx_bit_ff + 3'h1;
                    if (tx_bit_ff == 3'h7) begin
                        tx_state_ff <= (mode_ff == SPC_MODE1) ? SPC_ST_STOP : SPC_ST_NINTH;
                    end
                end
                SPC_ST_NINTH: begin
                    tx_state_ff <= SPC_ST_STOP;
                end
                default: begin
                    tx_state_ff <= SPC_ST_IDLE;
                end
            endcase
        end else if (async_tick && (tx_state_ff != SPC_ST_IDLE)) begin
            tx_cnt_ff <= tx_cnt_ff + 4'h1;
        end
    end

    // Line level per transmit state
    always_comb begin
        case (tx_state_ff)
            SPC_ST_START: tx_line = 1'b0;
            SPC_ST_DATA: tx_line = tx_shift_ff[0];
            SPC_ST_NINTH: tx_line = tx_ninth_ff;
            default: tx_line = 1'b1;
        endcase
    end

    // Receive sampling: majority of three mid-bit samples
    assign rx_start = (mode_ff != SPC_MODE0) && ren_ff && (rx_state_ff == SPC_ST_IDLE) && rx_prev_ff && !rxd_in;
    assign rx_mid = async_tick && (rx_cnt_ff == SPC_SAMPLE_C);
    assign rx_adv = async_tick && (rx_cnt_ff == SPC_TICK_LAST);
    assign rx_bit_now = (rx_smp_a_ff & rx_smp_b_ff) | (rx_smp_a_ff & rxd_in) | (rx_smp_b_ff & rxd_in);
    assign rx_stop_mid = rx_mid && (rx_state_ff == SPC_ST_STOP);
    // mode 1 keeps the stop bit, modes 2 and 3 the ninth bit
    assign rx_ninth_val = (mode_ff == SPC_MODE1) ? rx_bit_now : rx_ninth_ff;
    // with mpe set, a low stop or ninth bit drops the frame
    assign rx_accept = rx_stop_mid && fifo_in_ready && (!mpe_ff || rx_ninth_val);

    // Edge detect and sample capture
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rx_prev_ff <= 1'b1;
            rx_smp_a_ff <= 1'b1;
            rx_smp_b_ff <= 1'b1;
        end else begin
            rx_prev_ff <= rxd_in;
            if (async_tick && (rx_cnt_ff == SPC_SAMPLE_A)) begin
                rx_smp_a_ff <= rxd_in;
            end
            if (async_tick && (rx_cnt_ff == SPC_SAMPLE_B)) begin
                rx_smp_b_ff <= rxd_in;
            end
        end
    end

    // receive frame, decided at mid stop bit
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rx_state_ff <= SPC_ST_IDLE;
            rx_cnt_ff <= 4'h0;
            rx_bit_ff <= 3'h0;
            rx_shift_ff <= 8'h00;
            rx_ninth_ff <= 1'b0;
        end else if (!ren_ff || (mode_ff == SPC_MODE0)) begin
            rx_state_ff <= SPC_ST_IDLE;
        end else if (rx_start) begin
            rx_state_ff <= SPC_ST_START;
            rx_cnt_ff <= 4'h0;
            rx_bit_ff <= 3'h0;
        end else if (async_tick && (rx_state_ff != SPC_ST_IDLE)) begin
            rx_cnt_ff <= rx_cnt_ff + 4'h1;
            case (rx_state_ff)
                SPC_ST_START: begin
                    if (rx_mid && rx_bit_now) begin
                        rx_state_ff <= SPC_ST_IDLE;
                    end else if (rx_adv) begin
                        rx_state_ff <= SPC_ST_DATA;
                    end
                end
                SPC_ST_DATA: begin
                    if (rx_mid) begin
                        rx_shift_ff <= {rx_bit_now, rx_shift_ff[7:1]};
                    end
                    if (rx_adv) begin
                        rx_bit_ff <= rx_bit_ff + 3'h1;
                        if (rx_bit_ff == 3'h7) begin
                            rx_state_ff <= (mode_ff == SPC_MODE1) ? SPC_ST_STOP : SPC_ST_NINTH;
                        end
                    end
                end
                SPC_ST_NINTH: begin
                    if (rx_mid) begin
                        rx_ninth_ff <= rx_bit_now;
                    end
                    if (rx_adv) begin
                        rx_state_ff <= SPC_ST_STOP;
                    end
                end
                default: begin
                    if (rx_mid) begin
                        rx_state_ff <= SPC_ST_IDLE;
                    end
                end
            endcase
        end
    end

    assign ti_set = (m0_done && !m0_dir_rx_ff) || tx_to_stop;
    assign ri_set = (m0_done && m0_dir_rx_ff) || rx_accept;

    // Received bytes queue up so slow software does not lose them
    assign fifo_push = rx_accept || (m0_done && m0_dir_rx_ff);
    assign fifo_push_data = (mode_ff == SPC_MODE0) ? m0_shift_ff : rx_shift_ff;

    spc_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .in_valid_in(fifo_push),
        .in_ready_out(fifo_in_ready),
        .in_data_in(fifo_push_data),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(rd_buf),
        .out_data_out(fifo_out_data)
    );

    // mode 0 drives the shift clock, idle high
    assign nxt_txd = (mode_ff == SPC_MODE0) ? (!m0_active_ff || m0_sclk) : tx_line;
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            txd_ff <= 1'b1;
        end else begin
            txd_ff <= nxt_txd;
        end
    end
    assign txd_out = txd_ff;
    assign rxd_out = m0_shift_ff[0];
    assign rxd_oe_out = m0_active_ff && !m0_dir_rx_ff;

    sequence m0_rise_s;
        $rose(m0_sclk);
    endsequence

    sequence tx_stop_entry_s;
        $changed(tx_state_ff) && (tx_state_ff == SPC_ST_STOP);
    endsequence

    m0_slow_clock_a: assert property (m0_rise_s and (!mpe_ff && m0_bit_ff != 3'h7) |-> ##12 $rose(m0_sclk))
        else $error("mode 0 slow shift clock period wrong");
    m0_fast_clock_a: assert property (m0_rise_s and (mpe_ff && m0_bit_ff != 3'h7) |-> ##4 $rose(m0_sclk))
        else $error("mode 0 fast shift clock period wrong");
    m0_clock_pin_a: assert property (m0_active_ff |=> txd_out == $past(m0_sclk))
        else $error("shift clock missing on transmit pin");
    m0_tx_flag_a: assert property ((m0_done && !m0_dir_rx_ff) |=> ti_ff && !m0_active_ff)
        else $error("mode 0 transmit flag not set after eighth bit");
    m0_rx_flag_a: assert property ((m0_done && m0_dir_rx_ff) |=> ri_ff && fifo_out_valid)
        else $error("mode 0 receive flag not set after eighth bit");
    m0_drive_a: assert property ((m0_end && !m0_dir_rx_ff && !m0_done) |=> rxd_oe_out && rxd_out == $past(m0_shift_ff[1]))
        else $error("mode 0 transmit does not drive next data bit");
    tx_stop_flag_a: assert property (tx_stop_entry_s |-> ti_ff ##1 txd_out)
        else $error("transmit flag late at stop bit");
    tx_ninth_bit_a: assert property (($changed(tx_state_ff) && tx_state_ff == SPC_ST_NINTH) |=> txd_out == tx_ninth_ff)
        else $error("ninth bit on line differs from tx9");
    rx_off_a: assert property (!ren_ff |=> rx_state_ff == SPC_ST_IDLE && !$rose(m0_active_ff && m0_dir_rx_ff))
        else $error("receiver busy while disabled");
    rx_stop_filter_a: assert property ((rx_stop_mid && mpe_ff && mode_ff == SPC_MODE1 && !rx_bit_now && !ri_ff) |=> !ri_ff)
        else $error("low stop bit raised receive flag with mpe set");
    rx_ninth_filter_a: assert property ((rx_stop_mid && mpe_ff && mode_ff[1] && !rx_ninth_ff && !ri_ff) |=> !ri_ff)
        else $error("low ninth bit raised receive flag with mpe set");
    rx_rb8_load_a: assert property (rx_accept |=> rb8_ff == $past(rx_ninth_val) && ri_ff)
        else $error("received ninth field not stored");
    flag_set_only_a: assert property ($rose(ri_ff) |-> $past(ri_set))
        else $error("receive flag rose without a hardware event");
    flag_clear_a: assert property ((wr_ctrl && !sfr_wdata_in[SPC_BIT_TXDONE] && !ti_set) |=> !ti_ff)
        else $error("written zero did not clear transmit flag");

endmodule // spc_serial_port
